//--- src/pms_map.svh
// register map, field positions, reset values and timing counts
// assumes a 50 MHz core clock and word addressing on the register bus
//
// Overview of operation
// - brownout resets the processor by default; an option turns it into an interrupt
// - software switches brownout detection on or off; off means no reset or interrupt
// - when enabled, brownout condition follows the supply-below-trip report both ways
// - power-on flag sets at initial power-up and stays until software clears it
// - software can enter Idle, Power-down or Total Power-down
// - Idle halts the processor clock only; enabled interrupt or reset resumes it
// - cpu clock is the oscillator clock divided by a setting, up to 510
// - divider setting may change anytime; new ratio applies without any stall
// - Power-down stops the main oscillator, so cpu and derived clocks cease
// - Power-down ends on any reset or on a masked subset of enabled interrupts
// - brownout, watchdog, comparator and system timer keep running in Power-down
// - the comparator has its own power-down control, apart from the modes
// - RC oscillator stops in power-down unless it clocks the system and timer runs
// - Total Power-down is Power-down plus brownout detector and comparators off
// - power-on reset sets power-on and brownout flags, clears all other flags
// - an enabled keypad interrupt wakes the processor from Idle or Power-down
// - on wake-up from Power-down a timer holds the cpu clock until the source is stable
`ifndef PMS_MAP_SVH
`define PMS_MAP_SVH

// word indices; byte address is four times the index
`define PMS_OFF_CTRL        3'h0
`define PMS_OFF_DIV         3'h1
`define PMS_OFF_RESET_SOURCE_REGISTER      3'h2
`define PMS_OFF_STATUS      3'h3
`define PMS_OFF_WAKEMASK    3'h4

// reset values
`define PMS_CTRL_RESET      3'h1
`define PMS_DIV_RESET       8'h00
`define PMS_WAKEMASK_RESET  8'hFF
`define PMS_RESET_SOURCE_REGISTER_RESET    5'h03

// control field positions
`define PMS_CTRL_MODE_LO    4
`define PMS_CTRL_MODE_HI    5
`define PMS_REQ_IDLE        2'h1
`define PMS_REQ_PD          2'h2
`define PMS_REQ_TPD         2'h3

// reset source flag positions
`define PMS_FLAG_POF        0
`define PMS_FLAG_BOF        1

// wake-up stabilisation time
`define PMS_CLK_PERIOD_NS   20
`define PMS_WAKE_TIME_NS    2000
`define PMS_WAKE_CYCLES \
	((`PMS_WAKE_TIME_NS + `PMS_CLK_PERIOD_NS - 1) / `PMS_CLK_PERIOD_NS)

`endif

//--- src/pms_pkg.sv
// types shared by the power mode and supply monitor block
// assumes nothing beyond a SystemVerilog elaborator
package pms_pkg;

	// power states, one-hot
	typedef enum logic [4:0]
	{
		PMS_RUN  = 5'h01,
		PMS_IDLE = 5'h02,
		PMS_PD   = 5'h04,
		PMS_TPD  = 5'h08,
		PMS_WAKE = 5'h10
	} pms_state_type;

	// software control bits
	typedef struct packed
	{
		logic cmp_pd;
		logic bod_irq_mode;
		logic bod_en;
	} pms_ctrl_type;

	// reset source flags, bit order is the register layout
	typedef struct packed
	{
		logic sw;
		logic wdt;
		logic ext;
		logic brownout_flag;
		logic power_on_flag;
	} pms_flags_type;

	// non-power-on reset sources arriving as pulses
	typedef struct packed
	{
		logic sw;
		logic wdt;
		logic ext;
	} pms_rst_src_type;

endpackage : pms_pkg

//--- src/pms_clk_div.sv
// cpu clock enable divider
// assumes setting n divides by 2n, and n of zero divides by one
module pms_clk_div
	import pms_pkg::*;
#(
	parameter int DIV_W = 8
)
(
	input  wire logic             i_core_clk,
	input  wire logic             i_reset,
	input  wire logic [DIV_W-1:0] i_setting,
	input  wire logic             i_run,
	output logic                  o_tick
);

	logic [DIV_W:0] count_reg;
	logic [DIV_W:0] count_next;
	logic [DIV_W:0] last_cnt;
	logic           tick_reg;
	logic           tick_next;

	// compare with >= so a smaller setting never waits for a wrap
	always_comb
	begin
		if (i_setting == '0)
			last_cnt = '0;
		else
			last_cnt = {i_setting, 1'b0} - 1'b1;
		tick_next = i_run && (count_reg >= last_cnt);
		if (!i_run || count_reg >= last_cnt)
			count_next = '0;
		else
			count_next = count_reg + 1'b1;
	end

	always_ff @(posedge i_core_clk)
	begin
		if (i_reset)
		begin
			count_reg <= '0;
			tick_reg  <= 1'b0;
		end
		else
		begin
			count_reg <= count_next;
			tick_reg  <= tick_next;
		end
	end

	assign o_tick = tick_reg;

endmodule // pms_clk_div

//--- src/pms_wake_timer.sv
// wake-up hold-off timer
// assumes i_start is a one-cycle pulse; o_done pulses once after CYCLES
module pms_wake_timer
	import pms_pkg::*;
#(
	parameter int CYCLES = 100
)
(
	input  wire logic i_core_clk,
	input  wire logic i_reset,
	input  wire logic i_start,
	output logic      o_done
);

	localparam int CW = $clog2(CYCLES + 1);

	logic [CW-1:0] count_reg;
	logic [CW-1:0] count_next;
	logic          done_reg;
	logic          done_next;

	// count down; done on the final count
	always_comb
	begin
		count_next = count_reg;
		done_next  = 1'b0;
		if (i_start)
			count_next = CW'(CYCLES);
		else if (count_reg != '0)
		begin
			count_next = count_reg - 1'b1;
			done_next  = (count_reg == CW'(1));
		end
	end

	always_ff @(posedge i_core_clk)
	begin
		if (i_reset)
		begin
			count_reg <= '0;
			done_reg  <= 1'b0;
		end
		else
		begin
			count_reg <= count_next;
			done_reg  <= done_next;
		end
	end

	assign o_done = done_reg;

endmodule // pms_wake_timer

//--- src/pms_top.sv
// power mode control and supply monitor, Avalon-MM register slave
// assumes i_reset is the power-on reset; other resets arrive as pulses
// on i_rst_src; interrupt and supply inputs are synchronous to the clock
//
// Decided for this implementation: the address map and the Avalon-MM slave port.
`include "pms_map.svh"

module pms_top
	import pms_pkg::*;
#(
	parameter int IRQ_W       = 8,
	parameter int DIV_W       = 8,
	parameter int WAKE_CYCLES = `PMS_WAKE_CYCLES
)
(
	input  wire logic             i_core_clk,
	input  wire logic             i_reset,
	// register bus
	input  wire logic [2:0]       i_avs_address,
	input  wire logic             i_avs_read,
	input  wire logic             i_avs_write,
	input  wire logic [31:0]      i_avs_writedata,
	input  wire logic [3:0]       i_avs_byteenable,
	output logic      [31:0]      o_avs_readdata,
	output logic                  o_avs_waitrequest,
	// system inputs
	input  wire logic             i_supply_low,
	input  wire pms_rst_src_type  i_rst_src,
	input  wire logic [IRQ_W-1:0] i_irq_enabled,
	input  wire logic             i_keypad_irq,
	input  wire logic             i_rc_selected,
	input  wire logic             i_rtc_enabled,
	// controls out
	output logic                  o_cpu_clk_en,
	output logic                  o_periph_clk_en,
	output logic                  o_osc_enable,
	output logic                  o_rc_osc_enable,
	output logic                  o_bod_enable,
	output logic                  o_cmp_enable,
	output logic                  o_brownout_reset,
	output logic                  o_brownout_irq,
	output pms_state_type         o_power_state
);

	// refuse sizes the map cannot hold
	if (DIV_W < 1 || DIV_W > 8)
		$error("pms_top: DIV_W must be 1..8");
	if (IRQ_W < 1 || IRQ_W > 8)
		$error("pms_top: IRQ_W must be 1..8");
	if (WAKE_CYCLES < 1)
		$error("pms_top: WAKE_CYCLES must be at least 1");

	// address decode shared by read and write paths
	function automatic logic addr_is(input logic [2:0] a,
		input logic [2:0] off);
		addr_is = (a == off);
	endfunction

	// bus state
	logic                 wait_reg;
	logic                 wait_next;
	logic [31:0]          rdata_reg;
	logic [31:0]          rdata_next;
	logic [31:0]          rd_mux;
	logic                 bus_go;
	logic                 wr_en;

	// register state
	pms_ctrl_type         ctrl_reg;
	pms_ctrl_type         ctrl_next;
	logic [DIV_W-1:0]     div_reg;
	logic [DIV_W-1:0]     div_next;
	logic [IRQ_W-1:0]     mask_reg;
	logic [IRQ_W-1:0]     mask_next;
	pms_flags_type        flags_reg;
	pms_flags_type        flags_next;
	pms_flags_type        flags_set;

	// brownout state
	logic                 bod_on;
	logic                 cond_reg;
	logic                 cond_next;
	logic                 bor_reg;
	logic                 bor_next;
	logic                 boi_reg;
	logic                 boi_next;

	// mode state
	pms_state_type        state_reg;
	pms_state_type        state_next;
	logic [1:0]           mode_req;
	logic                 reset_any;
	logic                 wake_idle;
	logic                 wake_pd;
	logic                 wake_start;
	logic                 wake_done;

	// output flops
	logic                 osc_reg;
	logic                 osc_next;
	logic                 rc_reg;
	logic                 rc_next;
	logic                 cmp_reg;
	logic                 cmp_next;
	logic                 run_reg;
	logic                 run_next;
	logic                 bod_on_q;

	// bus handshake: one wait state, then the access completes
	always_comb
	begin
		bus_go = (i_avs_read || i_avs_write) && !wait_reg;
		wr_en  = i_avs_write && !wait_reg && i_avs_byteenable[0];
		if ((i_avs_read || i_avs_write) && wait_reg)
			wait_next = 1'b0;
		else
			wait_next = 1'b1;
	end

	// read mux; unmapped words read as zero
	always_comb
	begin
		rd_mux = 32'h0000_0000;
		if (addr_is(i_avs_address, `PMS_OFF_CTRL))
			rd_mux[2:0] = ctrl_reg;
		else if (addr_is(i_avs_address, `PMS_OFF_DIV))
			rd_mux[DIV_W-1:0] = div_reg;
		else if (addr_is(i_avs_address, `PMS_OFF_RESET_SOURCE_REGISTER))
			rd_mux[4:0] = flags_reg;
		else if (addr_is(i_avs_address, `PMS_OFF_STATUS))
			rd_mux[7:0] = {rc_reg, osc_reg, cond_reg, state_reg};
		else if (addr_is(i_avs_address, `PMS_OFF_WAKEMASK))
			rd_mux[IRQ_W-1:0] = mask_reg;
		// data is latched while waiting so it stands at the done edge
		if ((i_avs_read || i_avs_write) && wait_reg)
			rdata_next = rd_mux;
		else
			rdata_next = rdata_reg;
	end

	// control, divider and wake mask writes
	always_comb
	begin
		ctrl_next = ctrl_reg;
		div_next  = div_reg;
		mask_next = mask_reg;
		mode_req  = 2'h0;
		if (wr_en && addr_is(i_avs_address, `PMS_OFF_CTRL))
		begin
			ctrl_next = i_avs_writedata[2:0];
			mode_req  = i_avs_writedata[`PMS_CTRL_MODE_HI:
				`PMS_CTRL_MODE_LO];
		end
		if (wr_en && addr_is(i_avs_address, `PMS_OFF_DIV))
			div_next = i_avs_writedata[DIV_W-1:0];
		if (wr_en && addr_is(i_avs_address, `PMS_OFF_WAKEMASK))
			mask_next = i_avs_writedata[IRQ_W-1:0];
	end

	// brownout detector; dead when disabled or in total power-down
	always_comb
	begin
		bod_on    = ctrl_reg.bod_en && (state_reg != PMS_TPD);
		cond_next = bod_on && i_supply_low;
		bor_next  = cond_next && !ctrl_reg.bod_irq_mode;
		boi_next  = cond_next && ctrl_reg.bod_irq_mode;
	end

	// reset source flags; a set in the same cycle beats a clear
	always_comb
	begin
		flags_set     = '0;
		flags_set.brownout_flag = bor_next && !bor_reg;
		flags_set.ext = i_rst_src.ext;
		flags_set.wdt = i_rst_src.wdt;
		flags_set.sw  = i_rst_src.sw;
		flags_next    = flags_reg;
		if (wr_en && addr_is(i_avs_address, `PMS_OFF_RESET_SOURCE_REGISTER))
			flags_next = flags_reg & i_avs_writedata[4:0];
		flags_next = flags_next | flags_set;
	end

	// wake sources
	always_comb
	begin
		reset_any = (|i_rst_src) || bor_reg;
		wake_idle = (|i_irq_enabled) || i_keypad_irq || boi_reg
			|| reset_any;
		wake_pd   = (|(i_irq_enabled & mask_reg)) || i_keypad_irq
			|| reset_any;
	end

	// power mode sequencer
	always_comb
	begin
		state_next = state_reg;
		wake_start = 1'b0;
		unique case (state_reg)
			PMS_RUN:
			begin
				// a pending wake cancels the entry request
				if (!wake_idle)
				begin
					if (mode_req == `PMS_REQ_IDLE)
						state_next = PMS_IDLE;
					else if (mode_req == `PMS_REQ_PD)
						state_next = PMS_PD;
					else if (mode_req == `PMS_REQ_TPD)
						state_next = PMS_TPD;
				end
			end
			PMS_IDLE:
			begin
				// oscillator never stopped, so no hold-off
				if (wake_idle)
					state_next = PMS_RUN;
			end
			PMS_PD, PMS_TPD:
			begin
				if (wake_pd)
				begin
					state_next = PMS_WAKE;
					wake_start = 1'b1;
				end
			end
			PMS_WAKE:
			begin
				if (wake_done)
					state_next = PMS_RUN;
			end
		endcase
	end

	// clock and analog enables follow the next state
	always_comb
	begin
		osc_next = (state_next != PMS_PD) && (state_next != PMS_TPD);
		// rc keeps running in power-down only when it feeds a live system timer
		rc_next  = osc_next || (i_rc_selected && i_rtc_enabled);
		cmp_next = !ctrl_reg.cmp_pd && (state_next != PMS_TPD);
		run_next = (state_next == PMS_RUN);
	end

	// register all state
	always_ff @(posedge i_core_clk)
	begin
		if (i_reset)
		begin
			wait_reg  <= 1'b1;
			rdata_reg <= 32'h0000_0000;
			ctrl_reg  <= `PMS_CTRL_RESET;
			div_reg   <= DIV_W'(`PMS_DIV_RESET);
			mask_reg  <= IRQ_W'(`PMS_WAKEMASK_RESET);
			flags_reg <= pms_flags_type'(`PMS_RESET_SOURCE_REGISTER_RESET);
			cond_reg  <= 1'b0;
			bor_reg   <= 1'b0;
			boi_reg   <= 1'b0;
			state_reg <= PMS_RUN;
			osc_reg   <= 1'b1;
			rc_reg    <= 1'b1;
			cmp_reg   <= 1'b1;
			run_reg   <= 1'b1;
		end
		else
		begin
			wait_reg  <= wait_next;
			rdata_reg <= rdata_next;
			ctrl_reg  <= ctrl_next;
			div_reg   <= div_next;
			mask_reg  <= mask_next;
			flags_reg <= flags_next;
			cond_reg  <= cond_next;
			bor_reg   <= bor_next;
			boi_reg   <= boi_next;
			state_reg <= state_next;
			osc_reg   <= osc_next;
			rc_reg    <= rc_next;
			cmp_reg   <= cmp_next;
			run_reg   <= run_next;
		end
	end

	// divided cpu clock enable; held low outside run
	pms_clk_div #(
		.DIV_W (DIV_W)
	) u_div (
		.i_core_clk (i_core_clk),
		.i_reset    (i_reset),
		.i_setting  (div_reg),
		.i_run      (run_reg),
		.o_tick     (o_cpu_clk_en)
	);

	// stabilisation hold-off after power-down
	pms_wake_timer #(
		.CYCLES (WAKE_CYCLES)
	) u_wake (
		.i_core_clk (i_core_clk),
		.i_reset    (i_reset),
		.i_start    (wake_start),
		.o_done     (wake_done)
	);

	// all outputs straight from flops
	assign o_avs_readdata    = rdata_reg;
	assign o_avs_waitrequest = wait_reg;
	assign o_periph_clk_en   = osc_reg;
	assign o_osc_enable      = osc_reg;
	assign o_rc_osc_enable   = rc_reg;
	assign o_bod_enable      = bod_on_q;
	assign o_cmp_enable      = cmp_reg;
	assign o_brownout_reset  = bor_reg;
	assign o_brownout_irq    = boi_reg;
	assign o_power_state     = state_reg;

	// registered copy of the detector enable for the output
	always_ff @(posedge i_core_clk)
	begin
		if (i_reset)
			bod_on_q <= 1'b1;
		else
			bod_on_q <= bod_on;
	end

endmodule // pms_top

//--- test/pms_top_asserts.sv
// port-level checks for the power mode and supply monitor block
// assumes the bench sets WAKE_CYCLES to a handful of cycles
module pms_top_chk
	import pms_pkg::*;
#(
	parameter int IRQ_W = 8
)
(
	input wire logic             i_core_clk,
	input wire logic             i_reset,
	input wire logic             i_avs_read,
	input wire logic             i_avs_write,
	input wire logic             o_avs_waitrequest,
	input wire logic [IRQ_W-1:0] i_irq_enabled,
	input wire logic             i_keypad_irq,
	input wire logic             i_rc_selected,
	input wire logic             i_rtc_enabled,
	input wire logic             o_cpu_clk_en,
	input wire logic             o_periph_clk_en,
	input wire logic             o_osc_enable,
	input wire logic             o_rc_osc_enable,
	input wire logic             o_bod_enable,
	input wire logic             o_cmp_enable,
	input wire logic             o_brownout_reset,
	input wire logic             o_brownout_irq,
	input wire pms_state_type    o_power_state
);
	logic asleep;

	// either power-down flavour
	assign asleep = o_power_state == PMS_PD || o_power_state == PMS_TPD;

	default clocking dc @(posedge i_core_clk);
	endclocking
	default disable iff (i_reset);

	// sleep left for the hold-off state
	sequence s_sleep_wake;
		asleep ##1 o_power_state == PMS_WAKE;
	endsequence
	sequence s_held_off;
		(o_power_state == PMS_WAKE && !o_cpu_clk_en)[*3];
	endsequence

	a_wait_one: assert property ((i_avs_read || i_avs_write)
		&& o_avs_waitrequest |=> !o_avs_waitrequest)
		else $error("bus access not answered after one wait");
	a_wait_back: assert property (!o_avs_waitrequest |=> o_avs_waitrequest)
		else $error("waitrequest low for more than one cycle");
	a_brown_excl: assert property (!(o_brownout_reset && o_brownout_irq))
		else $error("brownout reset and interrupt together");
	a_bod_gate: assert property ((!o_bod_enable)[*3]
		|-> !o_brownout_reset && !o_brownout_irq)
		else $error("brownout output with detection off");
	a_cpu_halt: assert property ((o_power_state != PMS_RUN)[*2]
		|-> !o_cpu_clk_en)
		else $error("cpu clock outside run");
	a_idle_run: assert property ((o_power_state == PMS_IDLE)[*2]
		|-> o_periph_clk_en && o_osc_enable)
		else $error("peripherals stopped in idle");
	a_idle_exit: assert property (o_power_state == PMS_IDLE
		&& (|i_irq_enabled || i_keypad_irq) |-> ##[1:2] o_power_state == PMS_RUN)
		else $error("idle not left on interrupt");
	a_osc_stop: assert property (asleep[*2]
		|-> !o_osc_enable && !o_periph_clk_en)
		else $error("oscillator running in power-down");
	a_tpd_off: assert property ((o_power_state == PMS_TPD)[*2]
		|-> !o_bod_enable && !o_cmp_enable)
		else $error("detector or comparator on in total power-down");
	a_rc_keep: assert property ((asleep && i_rc_selected && i_rtc_enabled)[*2]
		|-> o_rc_osc_enable)
		else $error("rc oscillator stopped while clocking the timer");
	a_rc_stop: assert property ((asleep && !i_rc_selected)[*2]
		|-> !o_rc_osc_enable)
		else $error("rc oscillator running in power-down");
	a_wake_hold: assert property (s_sleep_wake |-> s_held_off)
		else $error("cpu clock ran during wake hold-off");
	a_wake_bound: assert property (s_sleep_wake
		|-> ##[1:8] o_power_state == PMS_RUN)
		else $error("wake hold-off did not end");
endmodule // pms_top_chk

bind pms_top pms_top_chk #(.IRQ_W(IRQ_W)) u_chk (.i_core_clk, .i_reset,
	.i_avs_read, .i_avs_write, .o_avs_waitrequest, .i_irq_enabled,
	.i_keypad_irq, .i_rc_selected, .i_rtc_enabled, .o_cpu_clk_en,
	.o_periph_clk_en, .o_osc_enable, .o_rc_osc_enable, .o_bod_enable,
	.o_cmp_enable, .o_brownout_reset, .o_brownout_irq, .o_power_state);

//--- test/pms_top_tb.sv
// self-checking bench: register accesses and power mode scenarios
// assumes the design sources and the checker are compiled first
`include "pms_map.svh"

module pms_top_tb
	import pms_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;

	logic            i_core_clk = 1'b0;
	logic            i_reset = 1'b1;
	logic [2:0]      i_avs_address = 3'h0;
	logic            i_avs_read = 1'b0;
	logic            i_avs_write = 1'b0;
	logic [31:0]     i_avs_writedata = 32'h0;
	logic [3:0]      i_avs_byteenable = 4'hF;
	logic            i_supply_low = 1'b0;
	pms_rst_src_type i_rst_src = 3'h0;
	logic [7:0]      i_irq_enabled = 8'h00;
	logic            i_keypad_irq = 1'b0;
	logic            i_rc_selected = 1'b0;
	logic            i_rtc_enabled = 1'b0;
	logic [31:0]     o_avs_readdata;
	logic            o_avs_waitrequest, o_cpu_clk_en, o_periph_clk_en;
	logic            o_osc_enable, o_rc_osc_enable, o_bod_enable;
	logic            o_cmp_enable, o_brownout_reset, o_brownout_irq;
	pms_state_type   o_power_state;
	int              mismatches = 0;
	int              checked = 0;
	int              cycles = 0;
	int              ticks = 0;
	int              t0 = 0;

	// short hold-off so wake-ups fit the bounded checks
	pms_top #(.WAKE_CYCLES(4)) dut (.i_core_clk, .i_reset, .i_avs_address,
		.i_avs_read, .i_avs_write, .i_avs_writedata, .i_avs_byteenable,
		.o_avs_readdata, .o_avs_waitrequest, .i_supply_low, .i_rst_src,
		.i_irq_enabled, .i_keypad_irq, .i_rc_selected, .i_rtc_enabled,
		.o_cpu_clk_en, .o_periph_clk_en, .o_osc_enable, .o_rc_osc_enable,
		.o_bod_enable, .o_cmp_enable, .o_brownout_reset, .o_brownout_irq,
		.o_power_state);

	always #10 i_core_clk = ~i_core_clk;

	// cpu clock pulses counted off the sampling edge to avoid races
	always @(negedge i_core_clk)
		if (o_cpu_clk_en === 1'b1)
			ticks++;

	// hang guard, run needs well under a thousand cycles
	always @(posedge i_core_clk)
	begin
		cycles++;
		if (cycles == 3000)
		begin
			mismatches++;
			test_done;
		end
	end

	task automatic test_done;
		$display("checked %0d mismatches %0d", checked, mismatches);
		if (mismatches == 0 && checked > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	task automatic check(input string what, input logic [31:0] seen, exp);
		checked++;
		if (seen !== exp)
		begin
			mismatches++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge i_core_clk);
	endtask

	// one access, held until waitrequest is sampled low
	task automatic bus(input logic wr, input logic [2:0] a,
		input logic [31:0] d, output logic [31:0] q);
		@(posedge i_core_clk);
		i_avs_address <= a;
		i_avs_writedata <= d;
		i_avs_write <= wr;
		i_avs_read <= !wr;
		do @(posedge i_core_clk); while (o_avs_waitrequest !== 1'b0);
		q = o_avs_readdata;
		i_avs_read <= 1'b0;
		i_avs_write <= 1'b0;
	endtask

	task automatic wr(input logic [2:0] a, input logic [31:0] d);
		logic [31:0] q;
		bus(1'b1, a, d, q);
	endtask

	task automatic rd(input logic [2:0] a, input logic [31:0] e, string w);
		logic [31:0] q;
		bus(1'b0, a, 32'h0, q);
		check(w, q, e);
	endtask

	task automatic st(input pms_state_type e, string w);
		check(w, 32'(o_power_state), 32'(e));
	endtask

	// main sequence
	initial
	begin
		tick(5);
		i_reset <= 1'b0;
		rd(`PMS_OFF_RESET_SOURCE_REGISTER, 32'h3, "reset_source_register");
		rd(`PMS_OFF_CTRL, 32'h1, "ctrl");
		rd(`PMS_OFF_WAKEMASK, 32'hFF, "wakemask");
		rd(3'h5, 32'h0, "unmapped");
		wr(`PMS_OFF_RESET_SOURCE_REGISTER, 32'h1E);
		rd(`PMS_OFF_RESET_SOURCE_REGISTER, 32'h2, "pof cleared");
		i_rst_src.ext <= 1'b1;
		tick(1);
		i_rst_src.ext <= 1'b0;
		rd(`PMS_OFF_RESET_SOURCE_REGISTER, 32'h6, "ext kept");
		// brownout in both modes, then detection off
		i_supply_low <= 1'b1;
		tick(4);
		check("bo reset", o_brownout_reset, 1'b1);
		wr(`PMS_OFF_CTRL, 32'h3);
		tick(3);
		check("bo irq", o_brownout_irq, 1'b1);
		check("bo reset off", o_brownout_reset, 1'b0);
		wr(`PMS_OFF_CTRL, 32'h2);
		tick(3);
		check("bo disabled", o_brownout_irq, 1'b0);
		wr(`PMS_OFF_CTRL, 32'h1);
		i_supply_low <= 1'b0;
		tick(3);
		check("bo released", o_brownout_reset, 1'b0);
		// idle and its exit, then a request blocked by a pending irq
		wr(`PMS_OFF_CTRL, 32'h11);
		tick(2);
		st(PMS_IDLE, "idle");
		i_irq_enabled <= 8'h80;
		tick(3);
		st(PMS_RUN, "idle exit");
		wr(`PMS_OFF_CTRL, 32'h11);
		tick(2);
		st(PMS_RUN, "wake beats entry");
		i_irq_enabled <= 8'h00;
		// power-down with rc keep-alive, keypad wake
		i_rc_selected <= 1'b1;
		i_rtc_enabled <= 1'b1;
		wr(`PMS_OFF_CTRL, 32'h21);
		tick(3);
		st(PMS_PD, "pd");
		check("osc off", o_osc_enable, 1'b0);
		check("bod alive", o_bod_enable, 1'b1);
		check("cmp alive", o_cmp_enable, 1'b1);
		check("rc kept", o_rc_osc_enable, 1'b1);
		i_rtc_enabled <= 1'b0;
		tick(3);
		check("rc off", o_rc_osc_enable, 1'b0);
		i_keypad_irq <= 1'b1;
		tick(2);
		st(PMS_WAKE, "hold-off");
		i_keypad_irq <= 1'b0;
		tick(8);
		st(PMS_RUN, "pd exit");
		// total power-down, masked irq ignored, unmasked wakes
		i_rc_selected <= 1'b0;
		wr(`PMS_OFF_WAKEMASK, 32'h01);
		wr(`PMS_OFF_CTRL, 32'h31);
		tick(3);
		st(PMS_TPD, "tpd");
		check("tpd bod", o_bod_enable, 1'b0);
		check("tpd cmp", o_cmp_enable, 1'b0);
		i_irq_enabled <= 8'h02;
		tick(3);
		st(PMS_TPD, "masked irq");
		i_irq_enabled <= 8'h01;
		tick(10);
		st(PMS_RUN, "tpd exit");
		i_irq_enabled <= 8'h00;
		// power-down left by a reset source, the advised wake path
		wr(`PMS_OFF_CTRL, 32'h21);
		tick(3);
		st(PMS_PD, "pd again");
		i_rst_src.sw <= 1'b1;
		tick(1);
		i_rst_src.sw <= 1'b0;
		tick(8);
		st(PMS_RUN, "reset wake");
		// comparator off on its own while running
		wr(`PMS_OFF_CTRL, 32'h5);
		tick(2);
		check("cmp pd", o_cmp_enable, 1'b0);
		// divider ratio 2n, then a change applies at once
		wr(`PMS_OFF_DIV, 32'h3);
		tick(4);
		t0 = ticks;
		tick(60);
		check("ratio 6", ticks - t0, 32'hA);
		wr(`PMS_OFF_DIV, 32'h0);
		tick(2);
		t0 = ticks;
		tick(20);
		check("ratio 1", ticks - t0, 32'h14);
		test_done;
	end
endmodule // pms_top_tb
